// [rtl/mie_core.sv]
`timescale 1ns/1ps
// Functional notes
// - Indirect load reads memory at selected pointer's address into the accumulator.
// - Mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Offset form addresses pointer plus signed offset -32..31, pointer unchanged.
// - After access pointer is plus one, minus one, or unchanged for offset.
// - Indirect window has no storage; accesses go to pointer's address.
// - Pointers are 16 bits and wrap modulo the range.
// - Bank literal load copies 5-bit immediate into bank select.
// - Page literal load copies 7-bit immediate into program counter high latch.
// - Accumulator literal load copies 8-bit immediate in one cycle, unless a memory answer loads the accumulator in that cycle.
// - Pointer stepping never modifies any status flag.
module mie_core #(
  parameter int unsigned PTR_W = mie_pkg::PTR_W,
  parameter int unsigned DATA_W = mie_pkg::DATA_W,
  parameter int unsigned OFS_W = mie_pkg::OFS_W,
  parameter int unsigned BANK_W = mie_pkg::BANK_W,
  parameter int unsigned PAGE_W = mie_pkg::PAGE_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Decoded indirect load request
  input wire logic i_ind_valid,
  input wire logic i_ind_sel,
  input wire logic [1:0] i_ind_mode,
  input wire logic i_ind_use_offset,
  input wire logic [OFS_W-1:0] i_ind_offset,
  // Decoded literal load request
  input wire logic [1:0] i_lit_op,
  input wire logic [DATA_W-1:0] i_lit_value,
  // Pointer write from core register path
  input wire logic i_ptr_wr,
  input wire logic i_ptr_wr_sel,
  input wire logic [PTR_W-1:0] i_ptr_wr_data,
  // Data memory read port
  output logic o_mem_rd,
  output logic [PTR_W-1:0] o_mem_addr,
  input wire logic i_mem_rvalid,
  input wire logic [DATA_W-1:0] i_mem_rdata,
  // Core state
  output logic o_busy,
  output logic o_done,
  output logic [DATA_W-1:0] o_accumulator,
  output logic o_zero_flag,
  output logic [BANK_W-1:0] o_bank_select,
  output logic [PAGE_W-1:0] o_program_counter_high_latch,
  output logic [PTR_W-1:0] o_file_pointer0,
  output logic [PTR_W-1:0] o_file_pointer1
);
  mie_pkg::mie_state_e state_q;
  mie_pkg::mie_state_e state_d;
  logic [PTR_W-1:0] ptr_q [mie_pkg::NUM_PTR];
  logic [PTR_W-1:0] ptr_d [mie_pkg::NUM_PTR];
  logic [PTR_W-1:0] addr_q;
  logic [PTR_W-1:0] addr_d;
  logic rd_q;
  logic rd_d;
  logic done_q;
  logic done_d;
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_d;
  logic zero_q;
  logic zero_d;
  logic [BANK_W-1:0] bank_q;
  logic [BANK_W-1:0] bank_d;
  logic [PAGE_W-1:0] page_q;
  logic [PAGE_W-1:0] page_d;
  logic [PTR_W-1:0] sel_ptr;
  logic [PTR_W-1:0] calc_addr;
  logic [PTR_W-1:0] calc_next;
  logic start;

  assign sel_ptr = ptr_q[i_ind_sel];
  assign start = i_ind_valid && (state_q == mie_pkg::MIE_IDLE);

  mie_ptr_calc #(
    .PTR_W(PTR_W),
    .OFS_W(OFS_W)
  ) u_calc (
    .i_ptr(sel_ptr),
    .i_mode(i_ind_mode),
    .i_use_offset(i_ind_use_offset),
    .i_offset(i_ind_offset),
    .o_addr(calc_addr),
    .o_ptr_next(calc_next)
  );

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    rd_d = 1'b0;
    done_d = 1'b0;
    acc_d = acc_q;
    zero_d = zero_q;
    bank_d = bank_q;
    page_d = page_q;
    for (int i = 0; i < mie_pkg::NUM_PTR; i++) begin
      ptr_d[i] = ptr_q[i];
    end
    if (i_ptr_wr) begin
      ptr_d[i_ptr_wr_sel] = i_ptr_wr_data;
    end
    case (state_q)
      mie_pkg::MIE_IDLE: begin
        if (start) begin
          // The window itself holds nothing; the read goes to the pointer address.
          addr_d = calc_addr;
          rd_d = 1'b1;
          // Pointer stepping leaves the zero flag alone.
          ptr_d[i_ind_sel] = calc_next;
          state_d = mie_pkg::MIE_WAIT;
        end
      end
      mie_pkg::MIE_WAIT: begin
        if (i_mem_rvalid) begin
          acc_d = i_mem_rdata;
          zero_d = (i_mem_rdata == mie_pkg::DATA_ZERO);
          done_d = 1'b1;
          state_d = mie_pkg::MIE_IDLE;
        end
      end
      default: begin
        state_d = mie_pkg::MIE_IDLE;
      end
    endcase
    // Literal loads never touch the zero flag.
    case (i_lit_op)
      mie_pkg::MIE_OP_BANK: begin
        bank_d = i_lit_value[BANK_W-1:0];
      end
      mie_pkg::MIE_OP_PAGE: begin
        page_d = i_lit_value[PAGE_W-1:0];
      end
      mie_pkg::MIE_OP_ACC: begin
        // A pending memory answer in the same cycle still wins the accumulator.
        if (!(state_q == mie_pkg::MIE_WAIT && i_mem_rvalid)) begin
          acc_d = i_lit_value;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= mie_pkg::MIE_IDLE;
      for (int i = 0; i < mie_pkg::NUM_PTR; i++) begin
        ptr_q[i] <= mie_pkg::PTR_RST;
      end
      addr_q <= mie_pkg::PTR_RST;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      acc_q <= mie_pkg::ACC_RST;
      zero_q <= 1'b0;
      bank_q <= mie_pkg::BANK_RST;
      page_q <= mie_pkg::PAGE_RST;
    end else begin
      state_q <= state_d;
      for (int i = 0; i < mie_pkg::NUM_PTR; i++) begin
        ptr_q[i] <= ptr_d[i];
      end
      addr_q <= addr_d;
      rd_q <= rd_d;
      done_q <= done_d;
      acc_q <= acc_d;
      zero_q <= zero_d;
      bank_q <= bank_d;
      page_q <= page_d;
    end
  end

  assign o_mem_rd = rd_q;
  assign o_mem_addr = addr_q;
  assign o_busy = (state_q == mie_pkg::MIE_WAIT);
  assign o_done = done_q;
  assign o_accumulator = acc_q;
  assign o_zero_flag = zero_q;
  assign o_bank_select = bank_q;
  assign o_program_counter_high_latch = page_q;
  assign o_file_pointer0 = ptr_q[0];
  assign o_file_pointer1 = ptr_q[1];
endmodule

// [rtl/mie_pkg.sv]
package mie_pkg;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BANK_W = 5;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned OFS_W = 6;
  localparam int unsigned NUM_PTR = 2;

  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;

  typedef enum logic [1:0] {
    MIE_OP_NONE = 2'b00,
    MIE_OP_BANK = 2'b01,
    MIE_OP_PAGE = 2'b10,
    MIE_OP_ACC = 2'b11
  } mie_lit_op_e;

  typedef enum logic [1:0] {
    MIE_IDLE = 2'b00,
    MIE_WAIT = 2'b01
  } mie_state_e;
endpackage

// [rtl/mie_ptr_calc.sv]
`timescale 1ns/1ps
// Address and pointer-update arithmetic for one indirect access.
module mie_ptr_calc #(
  parameter int unsigned PTR_W = mie_pkg::PTR_W,
  parameter int unsigned OFS_W = mie_pkg::OFS_W
) (
  // Operands
  input wire logic [PTR_W-1:0] i_ptr,
  input wire logic [1:0] i_mode,
  input wire logic i_use_offset,
  input wire logic [OFS_W-1:0] i_offset,
  // Results
  output logic [PTR_W-1:0] o_addr,
  output logic [PTR_W-1:0] o_ptr_next
);
  logic [PTR_W-1:0] inc_v;
  logic [PTR_W-1:0] dec_v;
  logic [PTR_W-1:0] ofs_ext;

  always_comb begin
    // Plain modular sums give the wraparound at both ends of the range.
    inc_v = i_ptr + mie_pkg::PTR_ONE;
    dec_v = i_ptr - mie_pkg::PTR_ONE;
    ofs_ext = {{(PTR_W-OFS_W){i_offset[OFS_W-1]}}, i_offset};
    if (i_use_offset) begin
      o_addr = i_ptr + ofs_ext;
      o_ptr_next = i_ptr;
    end else begin
      case (i_mode)
        mie_pkg::MODE_PRE_INC: begin
          o_addr = inc_v;
        end
        mie_pkg::MODE_PRE_DEC: begin
          o_addr = dec_v;
        end
        default: begin
          o_addr = i_ptr;
        end
      endcase
      o_ptr_next = i_mode[0] ? dec_v : inc_v;
    end
  end
endmodule

// [test/mie_core_asserts.sv]
`timescale 1ns/1ps
module mie_core_asserts (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [1:0] i_lit_op,
  input wire logic [7:0] i_lit_value,
  input wire logic i_mem_rvalid,
  input wire logic [7:0] i_mem_rdata,
  input wire logic o_mem_rd,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [7:0] o_accumulator,
  input wire logic o_zero_flag,
  input wire logic [4:0] o_bank_select,
  input wire logic [6:0] o_program_counter_high_latch
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_ans;
    o_busy && i_mem_rvalid;
  endsequence
  a_rd_pulse: assert property (o_mem_rd |-> o_busy ##1 !o_mem_rd) else $error("rd");
  a_busy_rd: assert property ($rose(o_busy) |-> o_mem_rd) else $error("busy");
  a_ans_load: assert property (s_ans |=> o_done && o_accumulator == $past(i_mem_rdata)) else $error("ld");
  a_zero_set: assert property (o_done |-> o_zero_flag == (o_accumulator == 8'h00)) else $error("z");
  a_flag_hold: assert property (!(o_busy && i_mem_rvalid) |=> $stable(o_zero_flag)) else $error("f");
  a_bank_lit: assert property (i_lit_op == 2'h1 |=> o_bank_select == $past(i_lit_value[4:0])) else $error("b");
  a_page_lit: assert property (i_lit_op == 2'h2 |=> o_program_counter_high_latch == $past(i_lit_value[6:0])) else $error("p");
  a_acc_lit: assert property (i_lit_op == 2'h3 && !(o_busy && i_mem_rvalid) |=> o_accumulator == $past(i_lit_value)) else $error("a");
endmodule
bind mie_core mie_core_asserts mie_core_asserts_inst (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_lit_op(i_lit_op), .i_lit_value(i_lit_value), .i_mem_rvalid(i_mem_rvalid),
  .i_mem_rdata(i_mem_rdata), .o_mem_rd(o_mem_rd), .o_busy(o_busy), .o_done(o_done),
  .o_accumulator(o_accumulator), .o_zero_flag(o_zero_flag), .o_bank_select(o_bank_select),
  .o_program_counter_high_latch(o_program_counter_high_latch));

// [test/mie_mem_model.sv]
`timescale 1ns/1ps
// Idle read data flips every cycle so a stale byte never passes for an answer.
module mie_mem_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic i_slow,
  output logic o_rvalid,
  output logic [7:0] o_rdata
);
  logic pend_q;
  logic [1:0] cnt_q;
  logic [15:0] a_q;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {pend_q, cnt_q, a_q, o_rvalid, o_rdata} <= '0;
    end else begin
      o_rvalid <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_rd) begin
        {pend_q, cnt_q, a_q} <= {1'b1, i_slow ? 2'h3 : 2'h0, i_addr};
      end else if (pend_q && cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end else if (pend_q) begin
        {pend_q, o_rvalid, o_rdata} <= {2'b01, a_q[7:0] ^ a_q[15:8] ^ 8'h3c};
      end
    end
  end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic i_clk = 0, i_nrst = 0, iv = 0, sel = 0, uo = 0, pw = 0, ps = 0, slow = 0;
  logic [1:0] mode = 0, lop = 0;
  logic [5:0] ofs = 0;
  logic [7:0] lval = 0, rdat, acc;
  logic [15:0] pd = 0, addr, fp0, fp1;
  logic rd, rv, busy, done, zf;
  logic [4:0] bank;
  logic [6:0] page;
  logic [15:0] ptr [2];
  int mismatches = 0, samples_checked = 0, cyc = 0;
  mie_core mie_core_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_ind_valid(iv), .i_ind_sel(sel),
    .i_ind_mode(mode), .i_ind_use_offset(uo), .i_ind_offset(ofs), .i_lit_op(lop),
    .i_lit_value(lval), .i_ptr_wr(pw), .i_ptr_wr_sel(ps), .i_ptr_wr_data(pd), .o_mem_rd(rd),
    .o_mem_addr(addr), .i_mem_rvalid(rv), .i_mem_rdata(rdat), .o_busy(busy), .o_done(done),
    .o_accumulator(acc), .o_zero_flag(zf), .o_bank_select(bank),
    .o_program_counter_high_latch(page), .o_file_pointer0(fp0), .o_file_pointer1(fp1));
  mie_mem_model mie_mem_model_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_rd(rd), .i_addr(addr),
    .i_slow(slow), .o_rvalid(rv), .o_rdata(rdat));
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      print_verdict;
    end
  end
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step;
    @(posedge i_clk);
    #1;
  endtask
  task automatic wptr(input logic s, input logic [15:0] d);
    {ps, pd, pw} = {s, d, 1'b1};
    step;
    pw = 0;
    ptr[s] = d;
    step;
  endtask
  task automatic ind(input logic s, input logic [1:0] m, input logic u, input logic [5:0] k);
    logic [15:0] a, p;
    p = ptr[s];
    a = u ? p + {{10{k[5]}}, k} : m[1] ? p : m[0] ? p - 16'h1 : p + 16'h1;
    if (!u) ptr[s] = m[0] ? p - 16'h1 : p + 16'h1;
    {sel, mode, uo, ofs, iv} = {s, m, u, k, 1'b1};
    step;
    iv = 0;
    chk("rd", 1, rd);
    chk("busy", 1, busy);
    chk("addr", a, addr);
    chk("ptr", ptr[s], s ? fp1 : fp0);
    repeat (10) if (!done) step;
    chk("done", 1, done);
    chk("idle", 0, busy);
    chk("acc", mem(a), acc);
    chk("zf", mem(a) == 8'h00, zf);
  endtask
  task automatic lit(input logic [1:0] o, input logic [7:0] v);
    logic z;
    z = zf;
    {lop, lval} = {o, v};
    step;
    lop = 0;
    chk("lit", o == 1 ? v[4:0] : o == 2 ? v[6:0] : v, o == 1 ? bank : o == 2 ? page : acc);
    chk("flag", z, zf);
    step;
  endtask
  task automatic print_verdict;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8c21b498));
    repeat (5) @(posedge i_clk);
    #1 i_nrst = 1;
    wptr(0, 16'hffff);
    ind(0, 2'h0, 0, 0);
    wptr(1, 16'h0000);
    ind(1, 2'h1, 0, 0);
    for (int m = 0; m < 4; m++) ind(m[0], m[1:0], 0, 0);
    wptr(0, 16'h003b);
    ind(0, 2'h0, 0, 0);
    ind(1, 2'h0, 1, 6'h20);
    ind(1, 2'h0, 1, 6'h1f);
    lit(1, 8'hff);
    lit(2, 8'hff);
    lit(3, 8'h00);
    // A reset in mid-run must clear pointers and core state alike.
    i_nrst = 0;
    ptr[0] = 16'h0000;
    ptr[1] = 16'h0000;
    step;
    chk("rst_ptr", 0, fp0 | fp1);
    chk("rst_acc", 0, {acc, zf, busy, done, rd});
    chk("rst_lit", 0, {bank, page});
    i_nrst = 1;
    repeat (80) begin
      slow = $urandom;
      case ($urandom % 3)
        0: ind($urandom, $urandom, $urandom, $urandom);
        1: lit($urandom % 3 + 1, $urandom);
        default: wptr($urandom, $urandom);
      endcase
    end
    print_verdict;
  end
endmodule
